// >>> src/sra_pkg.sv
/*
 * Shared constants for the serial register access link: bus address,
 * device control index, host command register map and link timing.
 * Assumes a single 50 MHz system clock at both ends.
 */
package sra_pkg;
	// -----------------------------------------------------------------
	// Device side
	// -----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR = 7'h1D;
	localparam logic [6:0] CTRL2_INDEX = 7'h21;
	localparam int WCS_BIT = 0;

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int SYS_PERIOD_NS = 20;
	localparam int I2C_HALF_NS = 1250;
	localparam int SPI_HALF_NS = 400;
	// Least times, so round up to whole cycles
	localparam logic [7:0] I2C_HALF_CYC =
		8'((I2C_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [7:0] SPI_HALF_CYC =
		8'((SPI_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

	// -----------------------------------------------------------------
	// Host command registers
	// -----------------------------------------------------------------
	localparam logic [2:0] HR_CTRL = 3'h0;
	localparam logic [2:0] HR_INDEX = 3'h1;
	localparam logic [2:0] HR_WDATA = 3'h2;
	localparam logic [2:0] HR_STATUS = 3'h3;
	localparam logic [2:0] HR_RDATA = 3'h4;
	localparam int CB_GO = 0;
	localparam int CB_RD = 1;
	localparam int CB_SPI = 2;
	localparam int CB_THREE = 3;
	localparam int CB_INC = 4;
	localparam int SB_BUSY = 0;
	localparam int SB_NACK = 1;
endpackage

// >>> src/sra_if.sv
/*
 * Pad carrier between the host end and the device end. Resolves the
 * shared pads from each side's drive and enable (enables active low).
 * Assumes nothing else drives the pads.
 */
`timescale 1ns/1ps
interface sra_if;
	logic h_cs_n;
	logic h_scl_o;
	logic h_scl_oe_n;
	logic h_sda_o;
	logic h_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;
	logic d_sdo_o;
	logic d_sdo_oe_n;
	logic cs_n;
	logic scl;
	logic sda;
	logic sdo;

	// -----------------------------------------------------------------
	// Pad resolution
	// -----------------------------------------------------------------
	// Internal pull-ups keep both lines high when nobody pulls low
	assign cs_n = h_cs_n;
	assign scl = !(!h_scl_oe_n && !h_scl_o);
	assign sda = !((!h_sda_oe_n && !h_sda_o) || (!d_sda_oe_n && !d_sda_o));
	assign sdo = d_sdo_oe_n ? 1'b1 : d_sdo_o;

	modport dev (input cs_n, input scl, input sda,
		output d_sda_o, output d_sda_oe_n, output d_sdo_o, output d_sdo_oe_n);
	modport host (output h_cs_n, output h_scl_o, output h_scl_oe_n,
		output h_sda_o, output h_sda_oe_n, input scl, input sda, input sdo);
endinterface

// >>> src/sra_dev.sv
/*
 * Device end: two-wire slave and synchronous serial port slave sharing
 * the same pads, both giving access to an 8-bit register space held by
 * user logic. Assumes user logic returns read data one cycle after
 * reg_rd and that the far end keeps the link rules that bind it.
 */
`timescale 1ns/1ps
module sra_dev
	import sra_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	sra_if.dev link,
	output logic [6:0] reg_index,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	output logic wire_count_select,
	output logic bus_busy
);
	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_RX = 3'b001,
		I_SACK = 3'b010,
		I_TX = 3'b011,
		I_MACK = 3'b100
	} sra_i2c_t;

	logic [2:0] pin_raw;
	logic [2:0] pin_f;
	logic [2:0] pin_p_reg;
	logic cs_f, scl_f, sda_f;
	logic scl_rise, scl_fall, cs_fall, i_start, i_stop, sp;

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	// A change counts once the second and third stages agree
	assign pin_raw = {link.cs_n, link.scl, link.sda};
	for (genvar g = 0; g < 3; g++) begin : g_sync
		logic s1_reg, s2_reg, s3_reg, f_reg;
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				s1_reg <= 1'b1;
				s2_reg <= 1'b1;
				s3_reg <= 1'b1;
				f_reg <= 1'b1;
			end else begin
				s1_reg <= pin_raw[g];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				if (s2_reg == s3_reg) f_reg <= s3_reg;
			end
		end
		assign pin_f[g] = f_reg;
	end

	// Previous filtered values for edge finding
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) pin_p_reg <= 3'h7;
		else pin_p_reg <= pin_f;
	end

	assign cs_f = pin_f[2];
	assign scl_f = pin_f[1];
	assign sda_f = pin_f[0];
	assign scl_rise = scl_f && !pin_p_reg[1];
	assign scl_fall = !scl_f && pin_p_reg[1];
	assign cs_fall = !cs_f && pin_p_reg[2];
	// Select high picks the two-wire bus, low the serial port
	assign sp = !cs_f && !cs_fall;
	// Data edge while the clock stays high
	assign i_start = cs_f && !sda_f && pin_p_reg[0] && scl_f && pin_p_reg[1];
	assign i_stop = cs_f && sda_f && !pin_p_reg[0] && scl_f && pin_p_reg[1];

	// -----------------------------------------------------------------
	// Two-wire slave
	// -----------------------------------------------------------------
	sra_i2c_t i_st;
	logic [3:0] i_bcnt;
	logic [1:0] i_byte;
	logic i_rw, i_acked;
	logic [7:0] i_sh;
	logic i_done, i_adr_ok;

	assign i_done = cs_f && i_st == I_RX && scl_fall && i_bcnt == 4'h8;
	assign i_adr_ok = i_done && i_byte == 2'h0 && i_sh[7:1] == SLAVE_ADDR;

	// Edges are found by oversampling, so any rate up to fast mode works
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			i_st <= I_IDLE;
			i_bcnt <= 4'h0;
			i_byte <= 2'h0;
			i_rw <= 1'b0;
			i_acked <= 1'b0;
			i_sh <= 8'h00;
			bus_busy <= 1'b0;
		end else if (!cs_f) begin
			i_st <= I_IDLE;
			bus_busy <= 1'b0;
		end else if (i_start) begin
			// Start and repeated start both restart the address phase
			i_st <= I_RX;
			i_bcnt <= 4'h0;
			i_byte <= 2'h0;
			i_rw <= 1'b0;
			bus_busy <= 1'b1;
		end else if (i_stop) begin
			i_st <= I_IDLE;
			bus_busy <= 1'b0;
		end else begin
			unique case (i_st)
				I_IDLE: begin
				end
				I_RX: begin
					if (scl_rise) begin
						i_sh <= {i_sh[6:0], sda_f};
						i_bcnt <= i_bcnt + 4'h1;
					end else if (i_done) begin
						i_bcnt <= 4'h0;
						// No match: leave the line high and drop out
						i_st <= (i_byte == 2'h0 && !i_adr_ok) ? I_IDLE : I_SACK;
						if (i_adr_ok) i_rw <= i_sh[0];
						if (i_byte != 2'h2) i_byte <= i_byte + 2'h1;
					end
				end
				I_SACK: begin
					if (scl_fall) i_st <= i_rw ? I_TX : I_RX;
				end
				I_TX: begin
					if (scl_rise) i_bcnt <= i_bcnt + 4'h1;
					else if (scl_fall && i_bcnt == 4'h8) begin
						i_st <= I_MACK;
						i_bcnt <= 4'h0;
					end
				end
				I_MACK: begin
					if (scl_rise) i_acked <= !sda_f;
					else if (scl_fall) i_st <= i_acked ? I_TX : I_IDLE;
				end
				default: i_st <= I_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Serial port slave
	// -----------------------------------------------------------------
	logic [2:0] p_pos;
	logic p_first, p_cmd, p_rw, p_drive;
	logic [7:0] p_sh;
	logic [7:0] p_byte;
	logic p_end;

	assign p_byte = {p_sh[6:0], sda_f};
	assign p_end = sp && scl_rise && p_pos == 3'h7;

	// Falling edges count bits, the first one after select is bit 0
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			p_pos <= 3'h7;
			p_first <= 1'b1;
			p_cmd <= 1'b1;
			p_rw <= 1'b0;
			p_drive <= 1'b0;
			p_sh <= 8'h00;
		end else if (cs_f) begin
			p_rw <= 1'b0;
			p_drive <= 1'b0;
		end else if (cs_fall) begin
			p_pos <= 3'h7;
			p_first <= 1'b1;
			p_cmd <= 1'b1;
			p_rw <= 1'b0;
			p_drive <= 1'b0;
		end else begin
			if (scl_fall) begin
				p_pos <= p_pos + 3'h1;
				p_first <= 1'b0;
				if (p_pos == 3'h7 && !p_first) p_cmd <= 1'b0;
				if (p_rw) p_drive <= 1'b1;
			end
			if (scl_rise) begin
				p_sh <= p_byte;
				if (p_cmd && p_pos == 3'h7) p_rw <= p_sh[6];
			end
		end
	end

	// -----------------------------------------------------------------
	// Shared register datapath
	// -----------------------------------------------------------------
	logic ev_idx, ev_wr, ev_fetch, ev_step, ev_shift, step_pend, inc_reg;
	logic [6:0] ev_idx_val;
	logic ev_inc_val;
	logic [7:0] ev_wdata;
	logic [7:0] tx_sh;
	logic out_reg, rd_take;

	assign ev_idx = (i_done && i_byte == 2'h1) || (p_end && p_cmd);
	// Index byte: low bits pick the register, top bit steps it
	// Command: bit 1 steps, bits 2-7 give the index
	assign ev_idx_val = cs_f ? i_sh[6:0] : {1'b0, p_byte[5:0]};
	assign ev_inc_val = cs_f ? i_sh[7] : p_byte[6];
	assign ev_wr = (i_done && i_byte == 2'h2) || (p_end && !p_cmd && !p_rw);
	assign ev_wdata = cs_f ? i_sh : p_byte;
	assign ev_step = (cs_f && i_st == I_MACK && scl_rise && !sda_f) ||
		(p_end && !p_cmd && p_rw);
	assign ev_fetch = ev_step || (i_adr_ok && i_sh[0]) || (p_end && p_cmd && p_byte[7]);
	assign ev_shift = (cs_f && scl_fall && ((i_st == I_SACK && i_rw) ||
		(i_st == I_TX && i_bcnt != 4'h8) || (i_st == I_MACK && i_acked))) ||
		(sp && scl_fall && p_rw);

	// A write steps the index one cycle late so reg_wr sees the old one
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_index <= 7'h00;
			inc_reg <= 1'b0;
			reg_wr <= 1'b0;
			reg_wdata <= 8'h00;
			reg_rd <= 1'b0;
			step_pend <= 1'b0;
			rd_take <= 1'b0;
		end else begin
			rd_take <= reg_rd; // User data only stands in the cycle after the strobe
			reg_wr <= ev_wr;
			reg_rd <= ev_fetch;
			step_pend <= ev_wr;
			if (ev_wr) reg_wdata <= ev_wdata;
			if (ev_idx) begin
				reg_index <= ev_idx_val;
				inc_reg <= ev_inc_val;
			end else if ((ev_step || step_pend) && inc_reg) begin
				reg_index <= reg_index + 7'h01;
			end
		end
	end

	// Transmit byte, shifted out MSB first on falling clock edges
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tx_sh <= 8'hFF;
			out_reg <= 1'b1;
		end else if (rd_take) begin
			tx_sh <= reg_rdata;
		end else if (ev_shift) begin
			out_reg <= tx_sh[7];
			tx_sh <= {tx_sh[6:0], 1'b0};
		end
	end

	// Wire count bit lives in the second control register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) wire_count_select <= 1'b0;
		else if (reg_wr && reg_index == CTRL2_INDEX) wire_count_select <= reg_wdata[WCS_BIT];
	end

	// -----------------------------------------------------------------
	// Pad drivers
	// -----------------------------------------------------------------
	// Two-wire side only ever pulls low: acknowledge or a zero data bit
	// Shared pad in single-line mode only during read data bits
	assign link.d_sda_o = cs_f ? 1'b0 : out_reg;
	assign link.d_sda_oe_n = cs_f ? !(i_st == I_SACK || (i_st == I_TX && !out_reg)) :
		!(p_drive && wire_count_select);
	assign link.d_sdo_o = out_reg;
	assign link.d_sdo_oe_n = !(!cs_f && p_drive && !wire_count_select);
endmodule // sra_dev

// >>> src/sra_host.sv
/*
 * Host end: a controller that runs one single-register write or read
 * over the two-wire bus or the serial port, ordered through a small
 * command register port. Assumes the device answers per the link rules.
 */
`timescale 1ns/1ps
module sra_host
	import sra_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	sra_if.host link,
	input wire logic [2:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output logic [7:0] cmd_rdata
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LOW = 3'b001,
		H_DATA = 3'b010,
		H_HIGH = 3'b011,
		H_SAMP = 3'b100,
		H_SFALL = 3'b101,
		H_SRISE = 3'b110,
		H_SEND = 3'b111
	} sra_hst_t;

	logic ctl_rd, ctl_spi, ctl_three, ctl_inc, busy_reg, nack_reg;
	logic [6:0] idx_reg;
	logic [7:0] wd_reg, rx_reg, hcnt, cur;
	logic [2:0] pin_raw, pin_f;
	logic go, tick, scl_s, sda_s, sdo_s, dval;
	logic [15:0] sword;

	// -----------------------------------------------------------------
	// Command registers
	// -----------------------------------------------------------------
	// Settings are refused while a transfer runs
	assign go = cmd_wr && cmd_addr == HR_CTRL && cmd_wdata[CB_GO] && !busy_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{ctl_rd, ctl_spi, ctl_three, ctl_inc} <= 4'h0;
			idx_reg <= 7'h00;
			wd_reg <= 8'h00;
		end else if (cmd_wr && !busy_reg) begin
			if (cmd_addr == HR_CTRL) begin
				ctl_rd <= cmd_wdata[CB_RD];
				ctl_spi <= cmd_wdata[CB_SPI];
				ctl_three <= cmd_wdata[CB_THREE];
				ctl_inc <= cmd_wdata[CB_INC];
			end
			if (cmd_addr == HR_INDEX) idx_reg <= cmd_wdata[6:0];
			if (cmd_addr == HR_WDATA) wd_reg <= cmd_wdata;
		end
	end

	// Read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) cmd_rdata <= 8'h00;
		else if (!cmd_rd) cmd_rdata <= 8'h00;
		else unique case (cmd_addr)
			HR_CTRL: cmd_rdata <= {3'h0, ctl_inc, ctl_three, ctl_spi, ctl_rd, 1'b0};
			HR_INDEX: cmd_rdata <= {1'b0, idx_reg};
			HR_WDATA: cmd_rdata <= wd_reg;
			HR_STATUS: cmd_rdata <= {6'h00, nack_reg, busy_reg};
			HR_RDATA: cmd_rdata <= rx_reg;
			default: cmd_rdata <= 8'h00;
		endcase
	end

	// -----------------------------------------------------------------
	// Half-period divider and pin synchronisers
	// -----------------------------------------------------------------
	assign tick = busy_reg && hcnt == 8'h00;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) hcnt <= 8'h00;
		else if (!busy_reg || hcnt == 8'h00) hcnt <= (ctl_spi ? SPI_HALF_CYC : I2C_HALF_CYC) - 8'h01;
		else hcnt <= hcnt - 8'h01;
	end

	assign pin_raw = {link.scl, link.sda, link.sdo};
	for (genvar g = 0; g < 3; g++) begin : g_sync
		logic s1_reg, s2_reg, s3_reg, f_reg;
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				s1_reg <= 1'b1;
				s2_reg <= 1'b1;
				s3_reg <= 1'b1;
				f_reg <= 1'b1;
			end else begin
				s1_reg <= pin_raw[g];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				if (s2_reg == s3_reg) f_reg <= s3_reg;
			end
		end
		assign pin_f[g] = f_reg;
	end
	assign {scl_s, sda_s, sdo_s} = pin_f;

	// -----------------------------------------------------------------
	// Transfer engine
	// -----------------------------------------------------------------
	sra_hst_t st;
	logic [3:0] bitn;
	logic [2:0] bseq;
	logic [1:0] ph;
	logic scl_r, sda_r, rel_r, cs_r;

	// Byte sequence: address+W, index, data | address+R, read byte
	always_comb begin
		unique case (bseq)
			3'h0: cur = {SLAVE_ADDR, 1'b0};
			3'h1: cur = {ctl_inc, idx_reg};
			3'h2: cur = wd_reg;
			3'h3: cur = {SLAVE_ADDR, 1'b1};
			default: cur = 8'hFF;
		endcase
	end
	// Ack slot released, also no-ack for the single read byte
	assign dval = ph == 2'h1 ? 1'b0 : (ph == 2'h2 ? 1'b1 : (bitn[3] ? 1'b1 : cur[~bitn[2:0]]));
	assign sword = {ctl_rd, ctl_inc, idx_reg[5:0], wd_reg};

	// In two-wire mode each half period changes one line only, so no false start or stop
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st <= H_IDLE;
			bitn <= 4'h0;
			bseq <= 3'h0;
			ph <= 2'h0;
			{scl_r, sda_r, rel_r, cs_r} <= 4'hF;
			busy_reg <= 1'b0;
			nack_reg <= 1'b0;
			rx_reg <= 8'h00;
		end else if (go) begin
			busy_reg <= 1'b1;
			nack_reg <= 1'b0;
			bitn <= 4'h0;
			bseq <= 3'h0;
			ph <= 2'h0;
			if (cmd_wdata[CB_SPI]) begin
				cs_r <= 1'b0;
				rel_r <= 1'b0;
				st <= H_SFALL;
			end else begin
				sda_r <= 1'b0;
				st <= H_LOW;
			end
		end else if (tick) begin
			unique case (st)
				H_IDLE: begin
				end
				H_LOW: begin
					scl_r <= 1'b0;
					st <= H_DATA;
				end
				H_DATA: begin
					sda_r <= dval;
					st <= H_HIGH;
				end
				H_HIGH: begin
					scl_r <= 1'b1;
					st <= H_SAMP;
				end
				H_SAMP: begin
					// A slave holding the clock low stretches this phase
					if (scl_s) begin
						st <= H_LOW;
						if (ph == 2'h1) begin
							sda_r <= 1'b1;
							busy_reg <= 1'b0;
							st <= H_IDLE;
						end else if (ph == 2'h2) begin
							sda_r <= 1'b0;
							ph <= 2'h0;
							bseq <= 3'h3;
						end else if (!bitn[3]) begin
							bitn <= bitn + 4'h1;
							if (bseq == 3'h4) rx_reg <= {rx_reg[6:0], sda_s};
						end else begin
							bitn <= 4'h0;
							if (bseq != 3'h4 && sda_s) begin
								nack_reg <= 1'b1;
								ph <= 2'h1;
							end else if (bseq == 3'h4 || bseq == 3'h2) begin
								ph <= 2'h1;
							end else if (bseq == 3'h1 && ctl_rd) begin
								ph <= 2'h2;
							end else begin
								bseq <= bseq + 3'h1;
							end
						end
					end
				end
				H_SFALL: begin
					scl_r <= 1'b0;
					sda_r <= sword[~bitn];
					rel_r <= ctl_three && ctl_rd && bitn[3];
					st <= H_SRISE;
				end
				H_SRISE: begin
					scl_r <= 1'b1;
					if (bitn[3] && ctl_rd) rx_reg <= {rx_reg[6:0], ctl_three ? sda_s : sdo_s};
					bitn <= bitn + 4'h1;
					st <= bitn == 4'hF ? H_SEND : H_SFALL;
				end
				H_SEND: begin
					cs_r <= 1'b1;
					rel_r <= 1'b1;
					sda_r <= 1'b1;
					busy_reg <= 1'b0;
					st <= H_IDLE;
				end
			endcase
		end
	end

	// Clock is released high between transfers, so select only changes with it high
	assign link.h_cs_n = cs_r;
	assign link.h_scl_o = 1'b0;
	assign link.h_scl_oe_n = scl_r;
	assign link.h_sda_o = ctl_spi ? sda_r : 1'b0;
	assign link.h_sda_oe_n = ctl_spi ? rel_r : sda_r;
endmodule // sra_host

// >>> bench/sra_link_sva.sv
/*
 * Checker for the pads between the host end and the device end.
 * Assumes it watches the resolved pads and drives of one sra_if, and
 * that the host runs single-register transfers only.
 */
`timescale 1ns/1ps
module sra_link_sva (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic scl,
	input wire logic h_sda_o,
	input wire logic d_sda_o,
	input wire logic d_sda_oe_n,
	input wire logic d_sdo_o,
	input wire logic d_sdo_oe_n
);
	// -----------------------------------------------------------------
	// Port clock edge counters, cleared while deselected
	// -----------------------------------------------------------------
	logic scl_q;
	logic [4:0] rise_cnt;
	logic [4:0] fall_cnt;

	// Previous clock level for edge finding
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) scl_q <= 1'b1;
		else scl_q <= scl;
	end

	// Rising edges inside one select window
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) rise_cnt <= 5'h00;
		else if (cs_n) rise_cnt <= 5'h00;
		else if (scl && !scl_q) rise_cnt <= rise_cnt + 5'h01;
	end

	// Falling edges: bit n starts at fall n+1
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) fall_cnt <= 5'h00;
		else if (cs_n) fall_cnt <= 5'h00;
		else if (!scl && scl_q) fall_cnt <= fall_cnt + 5'h01;
	end

	// -----------------------------------------------------------------
	// Properties
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	pulse_count_a: assert property ($rose(cs_n) |-> rise_cnt == 5'h10 && fall_cnt == 5'h10)
		else $error("port command did not span sixteen clock pulses");
	clk_idle_a: assert property ($changed(cs_n) |-> scl)
		else $error("port clock low while select changes");
	early_quiet_a: assert property ((!cs_n && fall_cnt < 5'h09) |-> d_sda_oe_n && d_sdo_oe_n)
		else $error("device drives data before bit eight");
	drive_start_a: assert property ((!cs_n && ($fell(d_sdo_oe_n) || $fell(d_sda_oe_n)))
		|-> fall_cnt == 5'h09)
		else $error("device read drive not started at bit eight");
	release_a: assert property ($rose(cs_n) |-> ##[0:8] (d_sda_oe_n && d_sdo_oe_n))
		else $error("device still drives after deselect");
	one_pin_a: assert property (!(!d_sda_oe_n && !d_sdo_oe_n))
		else $error("device drives both data pins");
	tw_no_sdo_a: assert property ((cs_n && $past(cs_n, 8)) |-> d_sdo_oe_n)
		else $error("data-out pin driven in two-wire mode");
	dev_hold_a: assert property ((!cs_n && scl && $past(scl))
		|-> (d_sdo_oe_n || $stable(d_sdo_o)) && (d_sda_oe_n || $stable(d_sda_o)))
		else $error("device data changed while port clock high");
	host_hold_a: assert property ((!cs_n && !$past(cs_n) && scl && $past(scl))
		|-> $stable(h_sda_o))
		else $error("host data changed while port clock high");
	tw_hold_a: assert property ((cs_n && $past(cs_n, 8) && scl && $past(scl))
		|-> $stable(d_sda_oe_n))
		else $error("slave moved data line while bus clock high");
endmodule // sra_link_sva

// >>> bench/test_serial_register_access_slave.sv
/*
 * Testbench: host end and device end joined by sra_if, a register
 * store on the device user port, commands through the host port.
 * Assumes a 50 MHz clock and single-register host transfers.
 */
`timescale 1ns/1ps
module test_serial_register_access_slave;
	import sra_pkg::*;
	logic clk_sys, rstn, cmd_wr, cmd_rd, reg_wr, reg_rd, wire_count_select, bus_busy;
	logic [2:0] cmd_addr;
	logic [7:0] cmd_wdata, cmd_rdata, reg_wdata, reg_rdata, last_dat, got, ctrl, idx, dat;
	logic [6:0] reg_index, last_idx;
	logic [7:0] regs [0:127];
	int n_mismatch, check_count, wr_cnt, n0;

	sra_if sra_if_i ();
	sra_host sra_host_i (.clk_sys(clk_sys), .rstn(rstn), .link(sra_if_i), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
	sra_dev sra_dev_i (.clk_sys(clk_sys), .rstn(rstn), .link(sra_if_i), .reg_index(reg_index),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.wire_count_select(wire_count_select), .bus_busy(bus_busy));
	sra_link_sva sra_link_sva_i (.clk_sys(clk_sys), .rstn(rstn), .cs_n(sra_if_i.cs_n),
		.scl(sra_if_i.scl), .h_sda_o(sra_if_i.h_sda_o), .d_sda_o(sra_if_i.d_sda_o),
		.d_sda_oe_n(sra_if_i.d_sda_oe_n), .d_sdo_o(sra_if_i.d_sdo_o),
		.d_sdo_oe_n(sra_if_i.d_sdo_oe_n));

	// -----------------------------------------------------------------
	// Clock and user register store
	// -----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Preset contents differ from any written value
	function automatic logic [7:0] pat(input logic [7:0] i);
		return i ^ 8'hC3;
	endfunction

	// Read data one cycle after the read pulse, as the device expects
	always @(posedge clk_sys) begin
		if (reg_wr) begin
			regs[reg_index] <= reg_wdata;
			last_idx <= reg_index;
			last_dat <= reg_wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (reg_rd) reg_rdata <= regs[reg_index];
	end

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cmd_wr <= 1'b1;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic host_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		cmd_rd <= 1'b1;
		cmd_addr <= a;
		@(posedge clk_sys);
		cmd_rd <= 1'b0;
		@(negedge clk_sys);
		d = cmd_rdata;
	endtask

	// One full transfer; busy is polled under a bound so a hang is counted
	task automatic xfer(input logic [7:0] c, input logic [7:0] i, input logic [7:0] d,
		output logic [7:0] rd);
		logic [7:0] st;
		int n;
		host_wr(HR_INDEX, i);
		host_wr(HR_WDATA, d);
		host_wr(HR_CTRL, c);
		repeat (200) @(posedge clk_sys);
		check("bus busy mid", {7'h00, bus_busy}, c[CB_SPI] ? 8'h00 : 8'h01);
		for (n = 0; n < 5000; n++) begin
			host_rd(HR_STATUS, st);
			if (st[SB_BUSY] === 1'b0) break;
		end
		check("done in time", n < 5000 ? 8'h01 : 8'h00, 8'h01);
		check("nack", st & 8'h03, 8'h00);
		// The stop reaches the device only through its pin filter
		repeat (8) @(posedge clk_sys);
		check("bus busy end", {7'h00, bus_busy}, 8'h00);
		host_rd(HR_RDATA, rd);
	endtask

	task conclude;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	// Modes: two-wire, serial 4-wire, serial 3-wire, each with step flag off and on
	initial begin
		rstn = 1'b0;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_addr = 3'h0;
		cmd_wdata = 8'h00;
		reg_rdata = 8'h00;
		n_mismatch = 0;
		check_count = 0;
		wr_cnt = 0;
		for (int i = 0; i < 128; i++) regs[i] = pat(8'(i));
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check("wcs reset", {7'h00, wire_count_select}, 8'h00);
		host_rd(3'h7, got);
		check("unmapped", got, 8'h00);
		for (int m = 0; m < 6; m++) begin
			if (m == 4) begin
				xfer(8'h01, {1'b0, CTRL2_INDEX}, 8'h01, got);
				check("wcs set", {7'h00, wire_count_select}, 8'h01);
			end
			ctrl = 8'h01 | (m >= 2 ? 8'h04 : 8'h00) | (m >= 4 ? 8'h08 : 8'h00)
				| (m % 2 == 1 ? 8'h10 : 8'h00);
			idx = 8'h08 + 8'(m);
			dat = 8'hA5 ^ 8'(m * 17);
			n0 = wr_cnt;
			xfer(ctrl, idx, dat, got);
			check("wr index", {1'b0, last_idx}, idx);
			check("wr data", last_dat, dat);
			check("wr count", 8'(wr_cnt - n0), 8'h01);
			xfer(ctrl | 8'h02, idx, 8'h00, got);
			check("rd back", got, dat);
			xfer(ctrl | 8'h02, idx + 8'h20, 8'h00, got);
			check("rd preset", got, pat(idx + 8'h20));
		end
		conclude;
	end

	// Run should take about 68000 cycles
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_mismatch++;
		conclude;
	end
endmodule // test_serial_register_access_slave
